// *** design/exec_unit_pkg.sv ***
package exec_unit_pkg;

  // Register bus geometry
  localparam int AXI_AW = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STAT = 6'h04;
  localparam logic [5:0] OFF_AF   = 6'h08;
  localparam logic [5:0] OFF_BC   = 6'h0C;
  localparam logic [5:0] OFF_DE   = 6'h10;
  localparam logic [5:0] OFF_PTR  = 6'h14;
  localparam logic [5:0] OFF_SP   = 6'h18;
  localparam logic [5:0] OFF_IDX1 = 6'h1C;
  localparam logic [5:0] OFF_PROG = 6'h20;

  // Control and status field positions
  localparam int CTRL_GO_BIT  = 0;
  localparam int CTRL_OP_LSB  = 8;
  localparam int CTRL_PFX_LSB = 16;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_IRQ     = 2;
  localparam int STAT_BADOP   = 3;

  // Flag bit positions in the flag byte
  localparam int FL_S  = 7;
  localparam int FL_Z  = 6;
  localparam int FL_H  = 4;
  localparam int FL_PV = 2;
  localparam int FL_N  = 1;
  localparam int FL_C  = 0;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Register file slots: B C D E H L F A
  localparam logic [2:0] IDX_B = 3'h0;
  localparam logic [2:0] IDX_C = 3'h1;
  localparam logic [2:0] IDX_H = 3'h4;
  localparam logic [2:0] IDX_L = 3'h5;
  localparam logic [2:0] IDX_F = 3'h6;
  localparam logic [2:0] IDX_A = 3'h7;

  // Prefixes and opcodes
  localparam logic [1:0] PFX_NONE = 2'h0;
  localparam logic [1:0] PFX_ED   = 2'h1;
  localparam logic [1:0] PFX_DD   = 2'h2;
  localparam logic [7:0] OP_JMP_REG = 8'hE9;
  localparam logic [7:0] OP_PORT_READ_STEP_UP     = 8'hA2;
  localparam logic [7:0] OP_PORT_READ_STEP_DOWN   = 8'hAA;
  localparam logic [7:0] OP_PORT_READ_REPEAT_UP   = 8'hB2;
  localparam logic [7:0] OP_PORT_READ_REPEAT_DOWN = 8'hBA;

  // Machine cycle lengths in T states; one T state is one MCLK period
  localparam logic [2:0] T_FETCH    = 3'h4;
  localparam logic [2:0] T_PAIR     = 3'h6;
  localparam logic [2:0] T_OPERAND  = 3'h3;
  localparam logic [2:0] T_BLK_M2   = 3'h5;
  localparam logic [2:0] T_SHORT    = 3'h3;
  localparam logic [2:0] T_LONG     = 3'h4;
  localparam logic [2:0] T_REPEAT   = 3'h5;
  localparam logic [2:0] T_REFRESH  = 3'h2;

  typedef enum logic [2:0] {
    K_NONE  = 3'b000,
    K_INC8  = 3'b001,
    K_INC16 = 3'b010,
    K_BLK   = 3'b011,
    K_JCOND = 3'b100,
    K_JREG  = 3'b101,
    K_JIDX  = 3'b110
  } kind_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M1     = 3'b001,
    M2     = 3'b010,
    M3     = 3'b011,
    M4     = 3'b100,
    M5     = 3'b101
  } mcyc_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        mem_rd;
    logic        mem_wr;
    logic        io_rd;
    logic        rfsh;
  } cpu_bus_s;

endpackage

// *** design/exec_unit.sv ***
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// RULE1: INC r sets S,Z,H,PV; clears N; keeps C
// RULE2: INC r takes four T states
// RULE3: register selector maps B C D E H L A
// RULE4: pair increment adds one; BC DE pointer SP
// RULE5: pair increment takes six T, flags kept
// RULE6: port address B:C, byte stored at pointer pair
// RULE7: step-down form decrements B and pointer; Z,N set
// RULE8: step-up form decrements B, increments pointer
// RULE9: single block forms take 4,5,3,4 T states
// RULE10: repeat forms rewind counter until B is zero
// RULE11: B of zero on entry moves 256 bytes
// RULE12: repeat gap: two refreshes, interrupts honoured
// RULE13: repeat-down iteration 21 T, final 16 T
// RULE14: repeat-up iteration 21 T, final 16 T
// RULE15: conditional jump loads target or skips past
// RULE16: condition field decodes Z, C, parity, sign tests
// RULE17: first operand byte low, second byte high
// RULE18: conditional jump takes 4,3,3 T, flags kept
// RULE19: opcode E9 loads pointer pair, four T
// RULE20: prefixed E9 loads index pair one
// RULE21: indexed jump takes 4,4 T, flags kept
// RULE22: undefined flags are left unchanged throughout
module exec_unit (
  // Clock and reset
  input  logic                                 MCLK,
  input  logic                                 RST,
  // AXI4-Lite write channels
  input  logic [exec_unit_pkg::AXI_AW-1:0]     S_AXI_AWADDR,
  input  logic                                 S_AXI_AWVALID,
  output logic                                 S_AXI_AWREADY,
  input  logic [31:0]                          S_AXI_WDATA,
  input  logic [3:0]                           S_AXI_WSTRB,
  input  logic                                 S_AXI_WVALID,
  output logic                                 S_AXI_WREADY,
  output logic [1:0]                           S_AXI_BRESP,
  output logic                                 S_AXI_BVALID,
  input  logic                                 S_AXI_BREADY,
  // AXI4-Lite read channels
  input  logic [exec_unit_pkg::AXI_AW-1:0]     S_AXI_ARADDR,
  input  logic                                 S_AXI_ARVALID,
  output logic                                 S_AXI_ARREADY,
  output logic [31:0]                          S_AXI_RDATA,
  output logic [1:0]                           S_AXI_RRESP,
  output logic                                 S_AXI_RVALID,
  input  logic                                 S_AXI_RREADY,
  // CPU address, data and strobes
  output exec_unit_pkg::cpu_bus_s              CPU_BUS,
  input  logic [7:0]                           CPU_DIN,
  input  logic                                 INT_REQ
);
  import exec_unit_pkg::*;

  // Architectural state
  logic [7:0]  r8 [0:7];
  logic [15:0] sp;
  logic [15:0] idx1;
  logic [15:0] pc;
  // Sequencer state
  mcyc_e       mc;
  kind_e       kind;
  logic [2:0]  tcnt;
  logic [7:0]  op;
  logic [1:0]  op_pfx;
  logic [7:0]  lo_byte;
  logic [7:0]  port_byte;
  logic [7:0]  cyc_cnt;
  logic        st_done;
  logic        st_irq;
  logic        st_bad;

  // Machine cycle length per instruction kind
  function automatic logic [2:0] m_len(kind_e k, logic up, mcyc_e m);
    logic [2:0] len;
    len = T_FETCH;
    case (m)
      M1:      len = (k == K_INC16) ? T_PAIR : T_FETCH;
      M2:      len = (k == K_BLK) ? T_BLK_M2 : ((k == K_JCOND) ? T_OPERAND : T_FETCH);
      M3:      len = (k == K_BLK) ? (up ? T_LONG : T_SHORT) : T_OPERAND; // RULE9 RULE18
      M4:      len = up ? T_SHORT : T_LONG; // RULE9 RULE13 RULE14
      M5:      len = T_REPEAT; // RULE13 RULE14
      default: len = T_FETCH;
    endcase
    return len;
  endfunction

  // Opcode classification
  function automatic kind_e decode(logic [1:0] pfx, logic [7:0] o);
    kind_e k;
    k = K_NONE;
    if (pfx == PFX_NONE) begin
      if (o[7:6] == 2'b00 && o[2:0] == 3'b100 && o[5:3] != 3'b110) k = K_INC8;
      else if (o[7:6] == 2'b00 && o[3:0] == 4'h3) k = K_INC16;
      else if (o[7:6] == 2'b11 && o[2:0] == 3'b010) k = K_JCOND;
      else if (o == OP_JMP_REG) k = K_JREG;
    end else if (pfx == PFX_ED) begin
      if (o == OP_PORT_READ_STEP_UP || o == OP_PORT_READ_STEP_DOWN ||
          o == OP_PORT_READ_REPEAT_UP || o == OP_PORT_READ_REPEAT_DOWN) k = K_BLK;
    end else if (pfx == PFX_DD && o == OP_JMP_REG) begin
      k = K_JIDX;
    end
    return k;
  endfunction

  // Condition test on the flag byte
  function automatic logic cond_true(logic [2:0] sel, logic [7:0] f);
    logic bit_v;
    case (sel[2:1])
      2'b00:   bit_v = f[FL_Z];
      2'b01:   bit_v = f[FL_C];
      2'b10:   bit_v = f[FL_PV];
      default: bit_v = f[FL_S];
    endcase
    return bit_v == sel[0]; // RULE16
  endfunction

  // Decode of the latched instruction
  wire [2:0]  sel8      = op[5:3]; // RULE3
  wire [1:0]  sel16     = op[5:4]; // RULE4
  wire [2:0]  pair_hi   = {sel16, 1'b0};
  wire [2:0]  pair_lo   = {sel16, 1'b1};
  wire        blk_up    = ~op[3];
  wire        blk_rpt   = op[4];
  wire [7:0]  flags     = r8[IDX_F];
  wire [15:0] ptr       = {r8[IDX_H], r8[IDX_L]};
  wire [7:0]  inc8_src  = r8[sel8];
  wire [7:0]  inc8_val  = inc8_src + 8'h01;
  wire [15:0] pair_val  = (sel16 == 2'h3) ? sp : {r8[pair_hi], r8[pair_lo]};
  wire [15:0] pair_inc  = pair_val + 16'h0001; // RULE4
  // B wraps from 00 to FF, so a zero start runs 256 transfers
  wire [7:0]  b_dec     = r8[IDX_B] - 8'h01; // RULE11
  wire [15:0] ptr_step  = blk_up ? ptr + 16'h0001 : ptr - 16'h0001;
  wire        rpt_more  = blk_rpt && (b_dec != 8'h00); // RULE10
  wire        cond_ok   = cond_true(op[5:3], flags);
  // Only the repeating up form swaps its port and memory cycle lengths
  wire [2:0]  cur_len   = m_len(kind, blk_up && blk_rpt, mc); // RULE9 RULE14
  wire        m_end     = (mc != M_IDLE) && (tcnt == cur_len - 3'h1);

  // Flag results: undefined block flags are simply kept
  wire [7:0] inc8_flags = {inc8_val[7], inc8_val == 8'h00, flags[5],
                           inc8_src[3:0] == 4'hF, flags[3], inc8_src == 8'h7F,
                           1'b0, flags[FL_C]}; // RULE1
  wire [7:0] blk_flags  = {flags[7], b_dec == 8'h00, flags[5:2], 1'b1, flags[0]}; // RULE7 RULE22

  // Register bus decode
  logic        aw_rdy;
  logic        ar_rdy;
  logic        b_vld;
  logic        r_vld;
  logic [1:0]  b_resp;
  logic [1:0]  r_resp;
  logic [31:0] r_data;
  wire         wr_fire  = aw_rdy;
  wire  [5:0]  wa       = S_AXI_AWADDR;
  wire         busy     = (mc != M_IDLE);
  wire         wa_pair  = (wa == OFF_AF) || (wa == OFF_BC) || (wa == OFF_DE) || (wa == OFF_PTR);
  wire         wa_word  = (wa == OFF_SP) || (wa == OFF_IDX1) || (wa == OFF_PROG);
  wire         wa_known = wa_pair || wa_word || (wa == OFF_CTRL) || (wa == OFF_STAT);
  // CPU state cannot be changed under a running instruction
  wire         wr_ok    = wa_known && !(busy && (wa_pair || wa_word || wa == OFF_CTRL));
  wire         wr_state = wr_fire && wr_ok && (wa_pair || wa_word);
  // Pair offsets 0C, 10, 14 are word slots 3, 4, 5; slot minus 3 picks the pair
  wire [1:0]   wr_pair  = 2'(wa[4:2] - 3'h3);
  wire [2:0]   wr_hi    = (wa == OFF_AF) ? IDX_A : {wr_pair, 1'b0};
  wire [2:0]   wr_lo    = (wa == OFF_AF) ? IDX_F : {wr_pair, 1'b1};
  wire [15:0]  wr_word  = S_AXI_WDATA[15:0];
  wire         go_req   = wr_fire && wr_ok && (wa == OFF_CTRL) && S_AXI_WSTRB[0]
                          && S_AXI_WDATA[CTRL_GO_BIT];
  wire [7:0]   go_op    = S_AXI_WDATA[CTRL_OP_LSB +: 8];
  wire [1:0]   go_pfx   = S_AXI_WDATA[CTRL_PFX_LSB +: 2];
  wire kind_e  go_kind  = decode(go_pfx, go_op);
  wire         start    = go_req && (go_kind != K_NONE);
  wire         clr_stat = wr_fire && (wa == OFF_STAT) && S_AXI_WSTRB[0];

  // Machine cycle sequencing
  mcyc_e      next_mc;
  logic [2:0] next_t;
  always_comb begin
    next_mc = mc;
    next_t  = busy ? tcnt + 3'h1 : 3'h0;
    if (start) begin
      next_mc = M1;
      next_t  = 3'h0;
    end else if (m_end) begin
      next_t = 3'h0;
      case (kind)
        K_JIDX:  next_mc = (mc == M1) ? M2 : M_IDLE;
        K_JCOND: next_mc = (mc == M3) ? M_IDLE : mcyc_e'(mc + 3'h1);
        K_BLK: begin
          if (mc == M4) next_mc = rpt_more ? M5 : M_IDLE; // RULE10
          else if (mc == M5) next_mc = INT_REQ ? M_IDLE : M1; // RULE12
          else next_mc = mcyc_e'(mc + 3'h1);
        end
        default: next_mc = M_IDLE;
      endcase
    end
  end
  wire fin      = m_end && (next_mc == M_IDLE);
  wire irq_stop = m_end && (mc == M5) && INT_REQ;

  // Bus pins for the cycle about to start
  wire [7:0] next_port = (kind == K_BLK && mc == M3 && m_end) ? CPU_DIN : port_byte;
  cpu_bus_s  next_bus;
  always_comb begin
    next_bus = '0;
    if (kind == K_JCOND && next_mc == M2) begin
      next_bus.addr   = pc + 16'h0001;
      next_bus.mem_rd = 1'b1;
    end else if (kind == K_JCOND && next_mc == M3) begin
      next_bus.addr   = pc + 16'h0002;
      next_bus.mem_rd = 1'b1;
    end else if (kind == K_BLK && next_mc == M3) begin
      next_bus.addr   = {r8[IDX_B], r8[IDX_C]}; // RULE6
      next_bus.io_rd  = 1'b1;
    end else if (kind == K_BLK && next_mc == M4) begin
      next_bus.addr   = ptr; // RULE6
      next_bus.dout   = next_port;
      next_bus.mem_wr = 1'b1;
    end else if (next_mc == M5) begin
      next_bus.rfsh   = (next_t < T_REFRESH); // RULE12
    end
  end

  // Sequencer, status and bus registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      mc <= M_IDLE;
      kind <= K_NONE;
      tcnt <= 3'h0;
      op <= RST_BYTE;
      op_pfx <= PFX_NONE;
      cyc_cnt <= RST_BYTE;
      st_done <= 1'b0;
      st_irq <= 1'b0;
      st_bad <= 1'b0;
      CPU_BUS <= '0;
    end else begin
      mc <= next_mc;
      tcnt <= next_t;
      CPU_BUS <= next_bus;
      cyc_cnt <= (start || (m_end && mc == M5)) ? 8'h00 : cyc_cnt + 8'h01;
      if (start) begin
        kind <= go_kind;
        op <= go_op;
        op_pfx <= go_pfx;
      end
      // A hardware set in the same cycle beats a software clear
      st_done <= fin || (st_done && !(clr_stat && S_AXI_WDATA[STAT_DONE]));
      st_irq <= irq_stop || (st_irq && !(clr_stat && S_AXI_WDATA[STAT_IRQ]));
      st_bad <= (go_req && go_kind == K_NONE)
                || (st_bad && !(clr_stat && S_AXI_WDATA[STAT_BADOP]));
    end
  end

  // Register file: software loads when idle, instructions update when busy
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) r8[i] <= RST_BYTE;
      sp <= RST_WORD;
      idx1 <= RST_WORD;
      pc <= RST_WORD;
      lo_byte <= RST_BYTE;
      port_byte <= RST_BYTE;
    end else if (wr_state) begin
      if (wa_pair && S_AXI_WSTRB[1]) r8[wr_hi] <= wr_word[15:8];
      if (wa_pair && S_AXI_WSTRB[0]) r8[wr_lo] <= wr_word[7:0];
      if (wa == OFF_SP && S_AXI_WSTRB[1:0] == 2'b11) sp <= wr_word;
      if (wa == OFF_IDX1 && S_AXI_WSTRB[1:0] == 2'b11) idx1 <= wr_word;
      if (wa == OFF_PROG && S_AXI_WSTRB[1:0] == 2'b11) pc <= wr_word;
    end else if (m_end) begin
      case (kind)
        K_INC8: begin
          r8[sel8] <= inc8_val; // RULE1 RULE2
          r8[IDX_F] <= inc8_flags; // RULE1
          pc <= pc + 16'h0001;
        end
        K_INC16: begin
          if (sel16 == 2'h3) sp <= pair_inc; // RULE5
          else {r8[pair_hi], r8[pair_lo]} <= pair_inc; // RULE4
          pc <= pc + 16'h0001;
        end
        K_JREG: pc <= ptr; // RULE19
        K_JIDX: if (mc == M2) pc <= idx1; // RULE20 RULE21
        K_JCOND: begin
          if (mc == M2) lo_byte <= CPU_DIN; // RULE17
          else if (mc == M3) pc <= cond_ok ? {CPU_DIN, lo_byte} : pc + 16'h0003; // RULE15
        end
        K_BLK: begin
          if (mc == M3) port_byte <= CPU_DIN;
          if (mc == M4) begin
            r8[IDX_B] <= b_dec; // RULE7 RULE8
            {r8[IDX_H], r8[IDX_L]} <= ptr_step; // RULE7 RULE8
            r8[IDX_F] <= blk_flags; // RULE7 RULE22
            // A repeat keeps the counter on its own opcode: only the pass that leaves B at zero adds 2
            if (!rpt_more) pc <= pc + 16'h0002; // RULE10
          end
        end
        default: pc <= pc;
      endcase
    end
  end

  // AXI4-Lite write: address and data are taken together
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aw_rdy <= 1'b0;
      b_vld <= 1'b0;
      b_resp <= RESP_OKAY;
    end else begin
      aw_rdy <= S_AXI_AWVALID && S_AXI_WVALID && !aw_rdy && !b_vld;
      if (aw_rdy) begin
        b_vld <= 1'b1;
        b_resp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        b_vld <= 1'b0;
      end
    end
  end

  // Read data selection
  wire [5:0] ra = S_AXI_ARADDR;
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (ra)
      OFF_CTRL: rd_mux = {14'h0000, op_pfx, op, 8'h00};
      OFF_STAT: rd_mux = {28'h0000000, st_bad, st_irq, st_done, busy};
      OFF_AF:   rd_mux = {16'h0000, r8[IDX_A], r8[IDX_F]};
      OFF_BC:   rd_mux = {16'h0000, r8[0], r8[1]};
      OFF_DE:   rd_mux = {16'h0000, r8[2], r8[3]};
      OFF_PTR:  rd_mux = {16'h0000, ptr};
      OFF_SP:   rd_mux = {16'h0000, sp};
      OFF_IDX1: rd_mux = {16'h0000, idx1};
      OFF_PROG: rd_mux = {16'h0000, pc};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // AXI4-Lite read: one outstanding read
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ar_rdy <= 1'b0;
      r_vld <= 1'b0;
      r_data <= 32'h00000000;
      r_resp <= RESP_OKAY;
    end else begin
      ar_rdy <= S_AXI_ARVALID && !ar_rdy && !r_vld;
      if (ar_rdy) begin
        r_vld <= 1'b1;
        r_data <= rd_mux;
        r_resp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        r_vld <= 1'b0;
      end
    end
  end

  assign S_AXI_AWREADY = aw_rdy;
  assign S_AXI_WREADY  = aw_rdy;
  assign S_AXI_BVALID  = b_vld;
  assign S_AXI_BRESP   = b_resp;
  assign S_AXI_ARREADY = ar_rdy;
  assign S_AXI_RVALID  = r_vld;
  assign S_AXI_RDATA   = r_data;
  assign S_AXI_RRESP   = r_resp;

  // Checks on timing and results
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_inc8_flags: assert property (fin && kind == K_INC8 |=> !flags[FL_N] // RULE1
    && flags[FL_C] == $past(flags[FL_C]) && flags[FL_PV] == ($past(inc8_src) == 8'h7F))
    else $error("increment flags wrong");
  a_inc8_time: assert property (fin && kind == K_INC8 |-> cyc_cnt == 8'd3) // RULE2
    else $error("register increment not four T states");
  a_pair_time: assert property (fin && kind == K_INC16 |-> cyc_cnt == 8'd5 // RULE5
    ##1 $stable(flags)) else $error("pair increment timing or flags wrong");
  a_port_addr: assert property (CPU_BUS.io_rd |-> CPU_BUS.addr == {r8[IDX_B], r8[IDX_C]}) // RULE6
    else $error("port address not B and C");
  a_blk_flags: assert property (m_end && kind == K_BLK && mc == M4 // RULE7
    |=> flags[FL_N] && flags[FL_Z] == (r8[IDX_B] == 8'h00)) else $error("block flags wrong");
  a_blk_time: assert property (fin && kind == K_BLK && !irq_stop |-> cyc_cnt == 8'd15) // RULE9
    else $error("block transfer not 16 T states");
  a_rpt_time: assert property (m_end && mc == M5 |-> cyc_cnt == 8'd20 // RULE13 RULE14
    ##1 $stable(pc)) else $error("repeat iteration not 21 T or counter moved");
  a_refresh_two: assert property ($rose(CPU_BUS.rfsh) |-> CPU_BUS.rfsh [*2] // RULE12
    ##1 !CPU_BUS.rfsh) else $error("refresh not two cycles");
  a_jcond_time: assert property (fin && kind == K_JCOND |-> cyc_cnt == 8'd9 // RULE18
    ##1 $stable(flags)) else $error("conditional jump timing wrong");
  a_jcond_pc: assert property (fin && kind == K_JCOND && cond_ok // RULE15
    |=> pc == {$past(CPU_DIN), lo_byte}) else $error("jump target wrong");
  a_jidx_time: assert property (fin && kind == K_JIDX |-> cyc_cnt == 8'd7 // RULE21
    ##1 pc == idx1) else $error("indexed jump wrong");

  c_inc8: cover property (fin && kind == K_INC8);
  c_repeat: cover property (m_end && mc == M5 && !INT_REQ);
  c_irq_stop: cover property (irq_stop);
  c_jump_taken: cover property (fin && kind == K_JCOND && cond_ok);

endmodule

// *** verification/bus_partner.sv ***
`timescale 1ns/1ps
module bus_partner (
  // Clock
  input  wire logic                    MCLK,
  // CPU side
  input  wire exec_unit_pkg::cpu_bus_s CPU_BUS,
  output logic [7:0]                   CPU_DIN
);
  import exec_unit_pkg::*;
  logic [7:0] mem [0:256-1];
  logic [7:0] last = 8'h5A;
  wire  [7:0] port_byte;
  // Port data follows the high address half, so every transfer sees a fresh byte
  assign port_byte = CPU_BUS.addr[15:8] ^ 8'hA5;
  // An idle bus shows the inverse of the last byte, so a late sample cannot pass
  assign CPU_DIN = CPU_BUS.io_rd ? port_byte : (CPU_BUS.mem_rd ? mem[CPU_BUS.addr[7:0]] : ~last);
  // Memory keeps only the low address byte; tests index it the same way, so addresses wrap inside one page
  always @(posedge MCLK) begin
    if (CPU_BUS.mem_rd || CPU_BUS.io_rd) last <= CPU_DIN;
    if (CPU_BUS.mem_wr) mem[CPU_BUS.addr[7:0]] <= CPU_BUS.dout;
  end
endmodule

// *** verification/tb_incr_block_input_jump_exec.sv ***
`timescale 1ns/1ps
module tb_incr_block_input_jump_exec;
  import exec_unit_pkg::*;
  logic              MCLK = 1'b0;
  logic              RST = 1'b1;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              arvalid = 1'b0;
  logic              int_req = 1'b0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = '0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, rr;
  logic [31:0]       rdata;
  cpu_bus_s          cbus;
  logic [7:0]        din;
  logic [15:0]       w [7];
  logic [5:0]        offs [7] = '{OFF_BC, OFF_DE, OFF_PTR, OFF_AF, OFF_SP, OFF_IDX1, OFF_PROG};
  int                err_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  logic [7:0]        ops [5] = '{8'hA2, 8'hAA, 8'hB2, 8'hBA, 8'hBA};
  logic [7:0]        bt [5] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h03};

  exec_unit i_dut (
    .MCLK          (MCLK),
    .RST           (RST),
    .S_AXI_AWADDR  (awaddr),
    .S_AXI_AWVALID (awvalid),
    .S_AXI_AWREADY (awready),
    .S_AXI_WDATA   (wdata),
    .S_AXI_WSTRB   (wstrb),
    .S_AXI_WVALID  (wvalid),
    .S_AXI_WREADY  (wready),
    .S_AXI_BRESP   (bresp),
    .S_AXI_BVALID  (bvalid),
    .S_AXI_BREADY  (1'b1),
    .S_AXI_ARADDR  (araddr),
    .S_AXI_ARVALID (arvalid),
    .S_AXI_ARREADY (arready),
    .S_AXI_RDATA   (rdata),
    .S_AXI_RRESP   (rresp),
    .S_AXI_RVALID  (rvalid),
    .S_AXI_RREADY  (1'b1),
    .CPU_BUS       (cbus),
    .CPU_DIN       (din),
    .INT_REQ       (int_req)
  );
  bus_partner i_mem (.MCLK(MCLK), .CPU_BUS(cbus), .CPU_DIN(din));

  // Clock, plus a cycle ceiling well above the longest sequence
  initial forever #25 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ready channels are held high, so only the valids move
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge MCLK); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge MCLK); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge MCLK); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge MCLK); while (rvalid !== 1'b1);
    d = rdata;
    rr = rresp;
  endtask

  task automatic load();
    logic [1:0] r;
    for (int i = 0; i < 7; i++) begin
      wr(offs[i], {16'h0, w[i]}, 4'hF, r);
      check(r, RESP_OKAY);
    end
  endtask

  task automatic verify();
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(offs[i], d);
      check(d, {16'h0, w[i]});
    end
  endtask

  // Status is probed one cycle before the final edge and again just after it
  task automatic run(input logic [7:0] op, input logic [1:0] pf, input int n,
                     input logic [3:0] st);
    logic [1:0]  r;
    logic [31:0] d;
    wr(OFF_STAT, 32'hE, 4'h1, r);
    fork
      wr(OFF_CTRL, {14'h0, pf, op, 8'h01}, 4'h7, r);
      begin
        do @(posedge MCLK); while (awready !== 1'b1);
        repeat (n - 3) @(posedge MCLK);
        rd(OFF_STAT, d);
        check(d[STAT_BUSY], 1'b1);
        rd(OFF_STAT, d);
        check(d[3:0], st);
      end
    join
  endtask

  function automatic logic [7:0] inc_flags(input logic [7:0] v, input logic [7:0] f);
    logic [7:0] res;
    res = v + 8'h01;
    return {res[7], res == 8'h00, f[5], v[3:0] == 4'hF, f[3], v == 8'h7F, 1'b0, f[0]};
  endfunction

  function automatic logic cond(input logic [2:0] c, input logic [7:0] f);
    logic b;
    b = (c[2:1] == 2'b00) ? f[FL_Z] : (c[2:1] == 2'b01) ? f[FL_C] :
        (c[2:1] == 2'b10) ? f[FL_PV] : f[FL_S];
    return b == c[0];
  endfunction

  task automatic rand_state();
    for (int i = 0; i < 7; i++) w[i] = 16'($urandom);
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [7:0]  v;
    logic [1:0]  r;
    logic [15:0] t;
    int          p;
    int          cnt;
    void'($urandom(47870));
    for (int i = 0; i < 7; i++) w[i] = RST_WORD;
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    verify();
    rd(6'h3C, d);
    check(rr, RESP_SLVERR);
    wr(6'h30, 32'h1, 4'hF, r);
    check(r, RESP_SLVERR);
    wr(OFF_CTRL, 32'h3401, 4'h3, r);
    rd(OFF_STAT, d);
    check(d[STAT_BADOP], 1'b1);
    // Eight-bit increments over every selector but 6, boundary operands first
    for (int k = 0; k < 8; k++) begin
      if (k != 6) begin
        rand_state();
        p = (k == 7) ? 3 : k / 2;
        v = (k == 0) ? 8'h7F : (k == 1) ? 8'hFF : (k == 2) ? 8'h0F : 8'($urandom);
        w[p] = (k % 2 == 0 || k == 7) ? {v, w[p][7:0]} : {w[p][15:8], v};
        load();
        run(8'(k * 8 + 4), PFX_NONE, 4, 4'h2);
        w[3][7:0] = inc_flags(v, w[3][7:0]);
        w[p] = (k % 2 == 0 || k == 7) ? {v + 8'h01, w[p][7:0]} : {w[p][15:8], v + 8'h01};
        w[6] = w[6] + 16'h1;
        verify();
      end
    end
    // Pair increments, one of them wrapping
    for (int s = 0; s < 4; s++) begin
      rand_state();
      p = (s == 3) ? 4 : s;
      if (s == 2) w[2] = 16'hFFFF;
      load();
      run(8'(s * 16 + 3), PFX_NONE, 6, 4'h2);
      w[p] = w[p] + 16'h1;
      w[6] = w[6] + 16'h1;
      verify();
    end
    // Conditional jumps, each condition twice with random flags
    for (int j = 0; j < 16; j++) begin
      rand_state();
      t = 16'($urandom);
      i_mem.mem[8'(w[6] + 16'h1)] = t[7:0];
      i_mem.mem[8'(w[6] + 16'h2)] = t[15:8];
      load();
      run(8'hC2 + 8'(j % 8 * 8), PFX_NONE, 10, 4'h2);
      w[6] = cond(3'(j), w[3][7:0]) ? t : w[6] + 16'h3;
      verify();
    end
    // Register-indirect jumps, plain and prefixed
    for (int j = 0; j < 2; j++) begin
      rand_state();
      load();
      run(OP_JMP_REG, j ? PFX_DD : PFX_NONE, j ? 8 : 4, 4'h2);
      w[6] = j ? w[5] : w[2];
      verify();
    end
    // Block input: every form, a 256-byte run and an interrupt stop
    for (int k = 0; k < 5; k++) begin
      rand_state();
      if (k != 1) w[0] = {bt[k], w[0][7:0]};
      cnt = (!ops[k][4] || k == 4) ? 1 : (w[0][15:8] == 8'h00) ? 256 : int'(w[0][15:8]);
      load();
      int_req <= (k == 4);
      run(ops[k], PFX_ED, (k == 4) ? 21 : ops[k][4] ? 21 * (cnt - 1) + 16 : 16,
          (k == 4) ? 4'h6 : 4'h2);
      int_req <= 1'b0;
      for (int i = 0; i < cnt; i++) begin
        check(i_mem.mem[w[2][7:0]], w[0][15:8] ^ 8'hA5);
        w[0] = w[0] - 16'h0100;
        w[2] = ops[k][3] ? w[2] - 16'h1 : w[2] + 16'h1;
      end
      w[3][7:0] = {w[3][7], w[0][15:8] == 8'h00, w[3][5:2], 1'b1, w[3][0]};
      w[6] = (k == 4) ? w[6] : w[6] + 16'h2;
      verify();
    end
    complete_run();
  end
endmodule
